// file: rtl/pmbpa_core.sv
/*
 Paged command addressing: page select, global page mask, write protect,
 bus address base and alternate host words; routes paged commands.
 Assumes REQ comes from a protocol engine on CLK; pins are asynchronous.
*/
// Function
// - pages 0..3 route to channels 0..3
// - page FF write hits all masked channels
// - only clear, operation, on/off take global
// - paged read at FF raises fault
// - unsupported global write dropped, raises fault
// - page byte at 0x00, resets 0x00
// - write protect byte 0x10, resets 0x00
// - global mask byte 0xE4, resets 0x0F
// - alternate host words at C8, C9, CA
// - linear word: 5-bit exponent, 11-bit mantissa
// - vout word unsigned, exponent minus thirteen
// - register format fields are bit defined
// - mask bits 3:0 enable channels, 7:4 zero
// - protect levels block writes; pin forces level2
// - address is base plus pin offset, offset capped at 8
`timescale 1ns/1ns
module pmbpa_core (
    input  wire logic                      CLK,        // 125 MHz clock
    input  wire logic                      ARST_N,     // async reset, low
    input  wire pmbpa_pkg::pmbpa_req_type  REQ,        // command from engine
    output logic [15:0]                    RDATA,      // read answer data
    output logic                           RVALID,     // read answer strobe
    output pmbpa_pkg::pmbpa_route_type     ROUTE,      // routed command
    output logic                           CML_FAULT,  // sticky page misuse
    input  wire logic                      FAULT_CLR,  // clear fault status
    input  wire logic                      WP_PIN,     // protect pin, async
    input  wire logic [3:0]                ADDR_OFS,   // address-select offset
    output logic [6:0]                     BUS_ADDR,   // slave address
    output logic [7:0]                     PAGE_SEL,   // current page
    input  wire logic [15:0]               LIN_WORD,   // linear word to split
    output pmbpa_pkg::pmbpa_lin_type       LIN_FIELDS, // exponent and mantissa
    output logic signed [5:0]              VOUT_EXP    // fixed vout exponent
);
    logic                       wp_meta;
    logic                       wp_sync;
    logic [3:0]                 ofs_meta;
    logic [3:0]                 ofs_sync;
    logic [7:0]                 page;
    logic [7:0]                 next_page;
    logic [7:0]                 wprot;
    logic [7:0]                 next_wprot;
    logic [7:0]                 gmask;
    logic [7:0]                 next_gmask;
    logic [7:0]                 abase;
    logic [7:0]                 next_abase;
    logic [15:0]                alt_cmd;
    logic [15:0]                next_alt_cmd;
    logic [15:0]                alt_d0;
    logic [15:0]                next_alt_d0;
    logic [15:0]                alt_d1;
    logic [15:0]                next_alt_d1;
    logic                       fault;
    logic                       next_fault;
    logic [15:0]                next_rdata;
    logic                       next_rvalid;
    pmbpa_pkg::pmbpa_route_type next_route;
    logic                       lvl1;
    logic                       lvl2;
    logic                       wr_ok;
    logic                       global_ok;
    logic                       misuse;
    logic [3:0]                 chan_dec;
    logic [3:0]                 ofs_clip;
    logic [6:0]                 next_bus_addr;
    pmbpa_pkg::pmbpa_lin_type   next_lin;

    // pin synchronisers
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            wp_meta  <= 1'b0;
            wp_sync  <= 1'b0;
            ofs_meta <= 4'h0;
            ofs_sync <= 4'h0;
        end
        else
        begin
            wp_meta  <= WP_PIN;
            wp_sync  <= wp_meta;
            ofs_meta <= ADDR_OFS;
            ofs_sync <= ofs_meta;
        end
    end

    // most restrictive of register and pin
    always_comb
    begin
        lvl1 = (wprot == pmbpa_pkg::WPROT_LEVEL1);
        lvl2 = (wprot == pmbpa_pkg::WPROT_LEVEL2) || wp_sync;
        wr_ok = 1'b1;
        if (lvl1)
        begin
            wr_ok = (REQ.code == pmbpa_pkg::CMD_WPROT)
                 || (REQ.code == pmbpa_pkg::CMD_PAGE)
                 || (REQ.code == pmbpa_pkg::CMD_NVM_UNLOCK)
                 || (REQ.code == pmbpa_pkg::CMD_STORE_ALL);
        end
        else if (lvl2)
        begin
            wr_ok = (REQ.code == pmbpa_pkg::CMD_WPROT)
                 || (REQ.code == pmbpa_pkg::CMD_PAGE)
                 || (REQ.code == pmbpa_pkg::CMD_NVM_UNLOCK)
                 || (REQ.code == pmbpa_pkg::CMD_STORE_ALL)
                 || (REQ.code == pmbpa_pkg::CMD_OPERATION)
                 || (REQ.code == pmbpa_pkg::CMD_ON_OFF_CFG)
                 || (REQ.code == pmbpa_pkg::CMD_ALT_CMD)
                 || (REQ.code == pmbpa_pkg::CMD_GMASK)
                 || (REQ.code == pmbpa_pkg::CMD_CLEAR_ENERGY)
                 || (REQ.code == pmbpa_pkg::CMD_CLEAR_FAULTS);
        end
        global_ok = (REQ.code == pmbpa_pkg::CMD_CLEAR_FAULTS)
                 || (REQ.code == pmbpa_pkg::CMD_OPERATION)
                 || (REQ.code == pmbpa_pkg::CMD_ON_OFF_CFG);
        misuse = REQ.valid && REQ.paged && (page == pmbpa_pkg::PAGE_ALL)
              && (!REQ.write || !global_ok);
        chan_dec = 4'h0;
        if (page == pmbpa_pkg::PAGE_ALL)
        begin
            chan_dec = gmask[3:0];
        end
        else if (page <= pmbpa_pkg::PAGE_LAST)
        begin
            chan_dec = 4'h1 << page[1:0];
        end
    end

    // register writes and routing
    always_comb
    begin
        next_page    = page;
        next_wprot   = wprot;
        next_gmask   = gmask;
        next_abase   = abase;
        next_alt_cmd = alt_cmd;
        next_alt_d0  = alt_d0;
        next_alt_d1  = alt_d1;
        next_rdata   = RDATA;
        next_rvalid  = 1'b0;
        next_route   = '0;
        next_fault   = fault;
        if (FAULT_CLR)
        begin
            next_fault = 1'b0;
        end
        if (misuse)
        begin
            next_fault = 1'b1;
        end
        if (REQ.valid && REQ.write && wr_ok && !REQ.paged)
        begin
            unique case (REQ.code)
                pmbpa_pkg::CMD_PAGE:      next_page    = REQ.data[7:0];
                pmbpa_pkg::CMD_WPROT:     next_wprot   = REQ.data[7:0];
                pmbpa_pkg::CMD_GMASK:
                    next_gmask = REQ.data[7:0] & pmbpa_pkg::GMASK_BITS;
                pmbpa_pkg::CMD_ADDR_BASE:
                    next_abase = REQ.data[7:0] & pmbpa_pkg::ADDR_BASE_BITS;
                pmbpa_pkg::CMD_ALT_CMD:   next_alt_cmd = REQ.data;
                pmbpa_pkg::CMD_ALT_DATA0: next_alt_d0  = REQ.data;
                pmbpa_pkg::CMD_ALT_DATA1: next_alt_d1  = REQ.data;
                default:                  next_page    = page;
            endcase
        end
        if (REQ.valid && !REQ.write && !REQ.paged)
        begin
            next_rvalid = 1'b1;
            unique case (REQ.code)
                pmbpa_pkg::CMD_PAGE:      next_rdata = {8'h00, page};
                pmbpa_pkg::CMD_WPROT:     next_rdata = {8'h00, wprot};
                pmbpa_pkg::CMD_GMASK:     next_rdata = {8'h00, gmask};
                pmbpa_pkg::CMD_ADDR_BASE: next_rdata = {8'h00, abase};
                pmbpa_pkg::CMD_ALT_CMD:   next_rdata = alt_cmd;
                pmbpa_pkg::CMD_ALT_DATA0: next_rdata = alt_d0;
                pmbpa_pkg::CMD_ALT_DATA1: next_rdata = alt_d1;
                default:                  next_rdata = pmbpa_pkg::WORD_RESET;
            endcase
        end
        if (REQ.valid && REQ.paged && !misuse && (!REQ.write || wr_ok))
        begin
            next_route.valid    = (chan_dec != 4'h0);
            next_route.write    = REQ.write;
            next_route.chan_sel = chan_dec;
            next_route.code     = REQ.code;
            next_route.data     = REQ.data;
        end
        if (misuse && !REQ.write)
        begin
            next_rvalid = 1'b1;
            next_rdata  = pmbpa_pkg::WORD_RESET;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            page    <= pmbpa_pkg::PAGE_RESET;
            wprot   <= pmbpa_pkg::WPROT_RESET;
            gmask   <= pmbpa_pkg::GMASK_RESET;
            abase   <= pmbpa_pkg::ADDR_BASE_RESET;
            alt_cmd <= pmbpa_pkg::WORD_RESET;
            alt_d0  <= pmbpa_pkg::WORD_RESET;
            alt_d1  <= pmbpa_pkg::WORD_RESET;
            fault   <= 1'b0;
            RDATA   <= pmbpa_pkg::WORD_RESET;
            RVALID  <= 1'b0;
            ROUTE   <= '0;
            BUS_ADDR   <= pmbpa_pkg::ADDR_BASE_RESET[6:0];
            LIN_FIELDS <= '0;
        end
        else
        begin
            page    <= next_page;
            wprot   <= next_wprot;
            gmask   <= next_gmask;
            abase   <= next_abase;
            alt_cmd <= next_alt_cmd;
            alt_d0  <= next_alt_d0;
            alt_d1  <= next_alt_d1;
            fault   <= next_fault;
            RDATA   <= next_rdata;
            RVALID  <= next_rvalid;
            ROUTE   <= next_route;
            BUS_ADDR   <= next_bus_addr;
            LIN_FIELDS <= next_lin;
        end
    end

    always_comb
    begin
        ofs_clip = (ofs_sync > pmbpa_pkg::ADDR_OFS_MAX) ? pmbpa_pkg::ADDR_OFS_MAX : ofs_sync;
        next_bus_addr = abase[6:0] + {3'b000, ofs_clip};
        next_lin = LIN_WORD;
    end

    assign PAGE_SEL   = page;
    assign CML_FAULT  = fault;
    assign VOUT_EXP   = pmbpa_pkg::VOUT_EXP;

    AST_MISUSE_FAULT: assert property (@(posedge CLK) disable iff (!ARST_N)
        misuse |=> CML_FAULT) else $error("misuse did not set fault");
    AST_GLOBAL_READ_NO_ROUTE: assert property (@(posedge CLK) disable iff (!ARST_N)
        (REQ.valid && REQ.paged && !REQ.write && page == pmbpa_pkg::PAGE_ALL)
        |=> !ROUTE.valid && RVALID) else $error("global read routed");
    AST_BAD_GLOBAL_WRITE: assert property (@(posedge CLK) disable iff (!ARST_N)
        (REQ.valid && REQ.paged && REQ.write && page == pmbpa_pkg::PAGE_ALL && !global_ok)
        |=> !ROUTE.valid) else $error("unsupported global write routed");
    AST_GLOBAL_MASK: assert property (@(posedge CLK) disable iff (!ARST_N)
        (REQ.valid && REQ.paged && REQ.write && page == pmbpa_pkg::PAGE_ALL && global_ok
         && wr_ok && gmask != 8'h00)
        |=> ROUTE.valid && ROUTE.chan_sel == $past(gmask[3:0])) else $error("mask route");
    AST_PAGE_ROUTE: assert property (@(posedge CLK) disable iff (!ARST_N)
        (REQ.valid && REQ.paged && page <= pmbpa_pkg::PAGE_LAST && (!REQ.write || wr_ok))
        |=> ROUTE.valid && ROUTE.chan_sel == (4'h1 << $past(page[1:0])))
        else $error("page route");
    AST_PAGE_WRITE: assert property (@(posedge CLK) disable iff (!ARST_N)
        (REQ.valid && REQ.write && !REQ.paged && REQ.code == pmbpa_pkg::CMD_PAGE)
        |=> PAGE_SEL == $past(REQ.data[7:0])) else $error("page not updated");
    AST_MASK_HIGH_ZERO: assert property (@(posedge CLK) disable iff (!ARST_N)
        gmask[7:4] == 4'h0 && abase[7] == 1'b0) else $error("reserved bits set");
    AST_LEVEL1_BLOCK: assert property (@(posedge CLK) disable iff (!ARST_N)
        (REQ.valid && REQ.write && !REQ.paged && lvl1 && REQ.code == pmbpa_pkg::CMD_GMASK)
        |=> $stable(gmask)) else $error("level1 write passed");
endmodule

// file: shared/pmbpa_pkg.sv
/*
 Constants and carrier types for the paged command addressing front end.
 Assumes a transaction-level command port from a bus protocol engine.
*/
package pmbpa_pkg;
    localparam logic [7:0]  CMD_PAGE         = 8'h00;
    localparam logic [7:0]  CMD_WPROT        = 8'h10;
    localparam logic [7:0]  CMD_ALT_CMD      = 8'hC8;
    localparam logic [7:0]  CMD_ALT_DATA0    = 8'hC9;
    localparam logic [7:0]  CMD_ALT_DATA1    = 8'hCA;
    localparam logic [7:0]  CMD_GMASK        = 8'hE4;
    localparam logic [7:0]  CMD_ADDR_BASE    = 8'hE6;
    localparam logic [7:0]  CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0]  CMD_OPERATION    = 8'h01;
    localparam logic [7:0]  CMD_ON_OFF_CFG   = 8'h02;
    localparam logic [7:0]  CMD_STORE_ALL    = 8'h15;
    localparam logic [7:0]  CMD_NVM_UNLOCK   = 8'hBD;
    localparam logic [7:0]  CMD_CLEAR_ENERGY = 8'hCC;
    localparam logic [7:0]  PAGE_ALL         = 8'hFF;
    localparam logic [7:0]  PAGE_LAST        = 8'h03;
    localparam logic [7:0]  PAGE_RESET       = 8'h00;
    localparam logic [7:0]  WPROT_RESET      = 8'h00;
    localparam logic [7:0]  WPROT_LEVEL1     = 8'h80;
    localparam logic [7:0]  WPROT_LEVEL2     = 8'h40;
    localparam logic [7:0]  GMASK_RESET      = 8'h0F;
    localparam logic [7:0]  GMASK_BITS       = 8'h0F;
    localparam logic [7:0]  ADDR_BASE_RESET  = 8'h5C;
    localparam logic [7:0]  ADDR_BASE_BITS   = 8'h7F;
    localparam logic [15:0] WORD_RESET       = 16'h0000;
    localparam logic [3:0]  ADDR_OFS_MAX     = 4'h8;
    localparam int          NUM_CHAN         = 4;
    localparam int          EXP_MSB          = 15;
    localparam int          EXP_LSB          = 11;
    localparam int          MANT_MSB         = 10;
    localparam logic signed [5:0] VOUT_EXP   = -6'sd13;

    // one command from the bus protocol engine
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        paged;
        logic [7:0]  code;
        logic [15:0] data;
    } pmbpa_req_type;

    // routed command toward the channel logic
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  chan_sel;
        logic [7:0]  code;
        logic [15:0] data;
    } pmbpa_route_type;

    // exponent-mantissa linear word, split
    typedef struct packed {
        logic signed [4:0]  exponent;
        logic signed [10:0] mantissa;
    } pmbpa_lin_type;
endpackage

// file: sim/pmbpa_host.sv
/*
 Host model issuing one command per call on the falling clock edge.
 Assumes the caller stands on a falling edge when it calls a task.
*/
`timescale 1ns/1ns
module pmbpa_host (
    input  wire logic                CLK, // bench clock
    output pmbpa_pkg::pmbpa_req_type REQ  // command toward the block
);
    initial REQ = '0;
    // request stands one cycle; the next call replaces it
    task automatic cmd(input logic w, input logic p, input logic [7:0] c, input logic [15:0] d);
        REQ = '{valid: 1'b1, write: w, paged: p, code: c, data: d};
        @(negedge CLK);
    endtask
    // released data must not show the last value
    task automatic idle();
        REQ = '{valid: 1'b0, write: REQ.write, paged: REQ.paged, code: REQ.code, data: ~REQ.data};
        @(negedge CLK);
    endtask
endmodule

// file: sim/tb.sv
/*
 Self-checking bench for the paged command front end with a behavioural model.
 Assumes the host model drives REQ and the bench drives the pins.
*/
`timescale 1ns/1ns
module tb;
    logic                       clk = 1'b0;
    logic                       arst_n = 1'b0;
    logic                       fault_clr = 1'b0;
    logic                       wp_pin = 1'b0;
    logic [3:0]                 addr_ofs = 4'h0;
    logic [15:0]                lin_word = 16'h0000;
    pmbpa_pkg::pmbpa_req_type   req;
    pmbpa_pkg::pmbpa_route_type route;
    pmbpa_pkg::pmbpa_lin_type   lin_fields;
    logic [15:0]                rdata;
    logic                       rvalid;
    logic                       cml_fault;
    logic [6:0]                 bus_addr;
    logic [7:0]                 page_sel;
    logic signed [5:0]          vout_exp;
    logic [31:0]                seed = 32'h0001_5777;
    logic [7:0]                 m_page = 8'h00;
    logic [7:0]                 m_wp = 8'h00;
    logic [3:0]                 m_mask = 4'hF;
    logic [6:0]                 m_base = 7'h5C;
    logic [15:0]                m_alt [3] = '{16'h0000, 16'h0000, 16'h0000};
    logic                       m_flt = 1'b0;
    int                         fail_count = 0;
    int                         samples_checked = 0;
    logic [7:0]                 regs [8] = '{8'h00, 8'h10, 8'hC8, 8'hC9, 8'hCA, 8'hE4,
                                             8'hE6, 8'h55};
    logic [25:0]                prot [11] = '{26'h210_0080, 26'h2E4_0003, 26'h0E4_0000,
        26'h200_0002, 26'h000_0000, 26'h210_0040, 26'h2E4_0005, 26'h2E6_0011,
        26'h0E4_0000, 26'h0E6_0000, 26'h210_0000};

    always #4 clk = ~clk;

    pmbpa_core u_dut (.CLK(clk), .ARST_N(arst_n), .REQ(req), .RDATA(rdata), .RVALID(rvalid),
        .ROUTE(route), .CML_FAULT(cml_fault), .FAULT_CLR(fault_clr), .WP_PIN(wp_pin),
        .ADDR_OFS(addr_ofs), .BUS_ADDR(bus_addr), .PAGE_SEL(page_sel), .LIN_WORD(lin_word),
        .LIN_FIELDS(lin_fields), .VOUT_EXP(vout_exp));
    pmbpa_host u_host (.CLK(clk), .REQ(req));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic bit wr_ok(input logic [7:0] c);
        if (m_wp == 8'h80)
            return c inside {8'h00, 8'h10, 8'h15, 8'hBD};
        if (m_wp == 8'h40 || wp_pin)
            return c inside {8'h00, 8'h10, 8'h15, 8'hBD, 8'h01, 8'h02, 8'h03, 8'hC8,
                             8'hE4, 8'hCC};
        return 1'b1;
    endfunction

    task automatic op(input logic w, input logic p, input logic [7:0] c, input logic [15:0] d);
        logic       ev;
        logic       er;
        logic [3:0] ch;
        logic [15:0] ed;
        ev = 1'b0;
        er = 1'b0;
        ch = 4'h0;
        ed = 16'h0000;
        if (w && !wr_ok(c))
            ev = 1'b0;
        else if (p && m_page <= 8'h03)
        begin
            ev = 1'b1;
            ch = 4'h1 << m_page;
        end
        else if (p && m_page == 8'hFF)
        begin
            if (w && c inside {8'h01, 8'h02, 8'h03})
            begin
                ev = (m_mask != 4'h0);
                ch = m_mask;
            end
            else
            begin
                m_flt = 1'b1;
                er = !w;
            end
        end
        else if (!p)
        begin
            er = !w;
            case (c)
                8'h00: if (w) m_page = d[7:0]; else ed = {8'h00, m_page};
                8'h10: if (w) m_wp = d[7:0]; else ed = {8'h00, m_wp};
                8'hE4: if (w) m_mask = d[3:0]; else ed = {12'h000, m_mask};
                8'hE6: if (w) m_base = d[6:0]; else ed = {9'h000, m_base};
                8'hC8, 8'hC9, 8'hCA: if (w) m_alt[c - 8'hC8] = d; else ed = m_alt[c - 8'hC8];
                default: ed = 16'h0000;
            endcase
        end
        u_host.cmd(w, p, c, d);
        chk("rvalid", {15'h0000, er}, {15'h0000, rvalid});
        if (er)
            chk("rdata", ed, rdata);
        chk("route_valid", {15'h0000, ev}, {15'h0000, route.valid});
        if (ev)
            chk("route", {3'h0, w, ch, c}, {3'h0, route.write, route.chan_sel, route.code});
        if (ev && w)
            chk("route_data", d, route.data);
        chk("fault", {15'h0000, m_flt}, {15'h0000, cml_fault});
        chk("page_sel", {8'h00, m_page}, {8'h00, page_sel});
    endtask

    task automatic clr();
        u_host.idle();
        fault_clr = 1'b1;
        @(negedge clk);
        fault_clr = 1'b0;
        m_flt = 1'b0;
        chk("fault_clr", 16'h0000, {15'h0000, cml_fault});
    endtask

    task automatic pin(input logic v);
        u_host.idle();
        wp_pin = v;
        repeat (3) @(negedge clk);
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        fail_count++;
        print_verdict();
    end

    initial
    begin
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        foreach (regs[i]) op(1'b0, 1'b0, regs[i], 16'h0000);
        u_host.idle();
        for (int i = 0; i <= 9; i++)
        begin
            addr_ofs = i[3:0];
            repeat (3) @(negedge clk);
            chk("bus_addr", 16'(7'h5C + ((i > 8) ? 7'd8 : 7'(i))), {9'h000, bus_addr});
        end
        foreach (regs[i])
        begin
            seed = lfsr(seed);
            if (regs[i] == 8'h00) seed[7:2] = 6'h00;
            op(1'b1, 1'b0, regs[i], seed[15:0]);
            op(1'b0, 1'b0, regs[i], 16'h0000);
        end
        op(1'b1, 1'b0, 8'h10, 16'h0000);
        u_host.idle();
        chk("bus_addr_base", {9'h000, 7'(m_base + 7'd8)}, {9'h000, bus_addr});
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            op(1'b1, 1'b0, 8'h00, 16'(i));
            op(i[0], 1'b1, 8'h21, seed[15:0]);
        end
        op(1'b1, 1'b0, 8'h00, 16'h0003);
        op(1'b0, 1'b1, 8'h21, 16'h0000);
        op(1'b1, 1'b0, 8'h00, 16'h00FF);
        for (int k = 0; k < 3; k++)
        begin
            seed = lfsr(seed);
            op(1'b1, 1'b0, 8'hE4, (k == 0) ? 16'h000F : ((k == 1) ? seed[31:16] : 16'h0000));
            for (int c = 1; c <= 3; c++) op(1'b1, 1'b1, 8'(c), seed[15:0]);
        end
        op(1'b1, 1'b1, 8'h21, 16'h1234);
        clr();
        op(1'b0, 1'b1, 8'h21, 16'h0000);
        clr();
        op(1'b1, 1'b0, 8'h00, 16'h0000);
        foreach (prot[i]) op(prot[i][25], prot[i][24], prot[i][23:16], prot[i][15:0]);
        pin(1'b1);
        op(1'b1, 1'b0, 8'hE6, 16'h0022);
        op(1'b1, 1'b0, 8'hC8, 16'hA5A5);
        op(1'b0, 1'b0, 8'hE6, 16'h0000);
        op(1'b0, 1'b0, 8'hC8, 16'h0000);
        pin(1'b0);
        op(1'b1, 1'b0, 8'hE6, 16'h0033);
        op(1'b0, 1'b0, 8'hE6, 16'h0000);
        u_host.idle();
        repeat (8)
        begin
            seed = lfsr(seed);
            lin_word = seed[15:0];
            @(negedge clk);
            chk("lin_exp", {11'h000, lin_word[15:11]}, {11'h000, lin_fields.exponent});
            chk("lin_mant", {5'h00, lin_word[10:0]}, {5'h00, lin_fields.mantissa});
        end
        chk("vout_exp", 16'hFFF3, 16'(vout_exp));
        print_verdict();
    end
endmodule
